// ---- verilog/mcas_cfg.svh ----
// Constants of the multichannel acquisition sequencer
`ifndef MCAS_CFG_SVH
`define MCAS_CFG_SVH
`define MCAS_ST_DONE 2'h0
`define MCAS_ST_XFER 2'h1
`define MCAS_ST_TRIG 2'h2
`define MCAS_ST_DELAY 2'h3
`define MCAS_SRC_INT 2'h0
`define MCAS_SRC_SINE 2'h1
`define MCAS_SRC_SQR 2'h2
`define MCAS_DIV_MIN 11'h002
`define MCAS_DIV_MAX 11'h400
`define MCAS_DIV_RESET 11'h002
`define MCAS_BUF_TOTAL 16'h8000
`define MCAS_BUF_AW 15
`define MCAS_CH_LAST2 2'h1
`define MCAS_CH_LAST4 2'h3
`define MCAS_FLAG_BIT 3
`define MCAS_FIFO_DEPTH 2
`endif

// ---- verilog/mcas_pkg.sv ----
// Types of the multichannel acquisition sequencer
`default_nettype none
package mcas_pkg;
    typedef enum logic [1:0] {
        MCAS_IDLE = 2'h0,
        MCAS_WAIT_TRIG = 2'h1,
        MCAS_DELAY = 2'h3,
        MCAS_RUN = 2'h2
    } mcas_state_t;
    typedef logic [15:0] mcas_word_t;
endpackage
`default_nettype wire

// ---- verilog/mcas_skid.sv ----
// Two-entry buffer in the sample word path
`default_nettype none
module mcas_skid (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire mcas_pkg::mcas_word_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output mcas_pkg::mcas_word_t out_data
);
    import mcas_pkg::*;
    mcas_word_t mem_q [2];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rp_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end else if (clk_en) begin
            if (push) wp_q <= ~wp_q;
            if (pop) rp_q <= ~rp_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge sys_clk) begin
        if (clk_en && push) mem_q[wp_q] <= in_data;
    end
endmodule // mcas_skid
`default_nettype wire

// ---- verilog/mcas_seq.sv ----
// Acquisition sequencer: clock division, channel scan, packing, counting
`include "mcas_cfg.svh"
`default_nettype none
module mcas_seq (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Configuration
    input wire logic [2:0] enabled_channel_count,
    input wire logic [1:0] clock_source_select,
    input wire logic converter_faster_than_bus,
    input wire logic [10:0] clock_divisor,
    input wire logic config_write,
    input wire logic ten_bit_variant,
    input wire logic use_trigger,
    input wire logic [15:0] post_trigger_preload,
    input wire logic [31:0] conversion_count,
    input wire logic start,
    input wire logic stop,
    // Pins from outside the clock domain
    input wire logic internal_clock_tick,
    input wire logic external_sine_clock,
    input wire logic external_square_clock_choice,
    input wire logic trigger_in,
    input wire logic [2:0] digital_inputs,
    input wire logic [11:0] converter_data [4],
    // Word stream toward the DMA path
    output logic sample_valid,
    input wire logic sample_ready,
    output mcas_pkg::mcas_word_t sample_word,
    // Status
    output logic [1:0] acquisition_status,
    output logic [31:0] transferred_count,
    output logic [14:0] oldest_sample_index,
    output logic [15:0] samples_per_channel,
    output logic [15:0] post_trigger_remaining,
    output logic divisor_rejected,
    output logic source_rejected,
    output logic channel_count_rejected,
    output logic converter_faster_q
);
    import mcas_pkg::*;

    function automatic logic [3:0] ch_mask(input logic [2:0] n);
        case (n)
            3'h1: ch_mask = 4'h1;
            3'h2: ch_mask = 4'h3;
            3'h4: ch_mask = 4'hf;
            default: ch_mask = 4'h0;
        endcase
    endfunction

    function automatic logic div_ok(input logic [10:0] d);
        div_ok = !d[0] && d >= `MCAS_DIV_MIN && d <= `MCAS_DIV_MAX;
    endfunction

    // Two-flop synchronisers for every pin input
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [2:0] di1_q;
    logic [2:0] di2_q;
    logic [11:0] ad1_q [4];
    logic [11:0] ad2_q [4];
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            di1_q <= 3'h0;
            di2_q <= 3'h0;
        end else if (clk_en) begin
            s1_q <= {trigger_in, external_square_clock_choice, external_sine_clock,
                     internal_clock_tick};
            s2_q <= s1_q;
            di1_q <= digital_inputs;
            di2_q <= di1_q;
        end
    end
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_adsync
            always_ff @(posedge sys_clk) begin
                if (clk_en) begin
                    ad1_q[g] <= converter_data[g];
                    ad2_q[g] <= ad1_q[g];
                end
            end
        end
    endgenerate

    // Configuration registers
    logic [2:0] chn_q;
    logic [1:0] src_q;
    logic [10:0] div_q;
    logic ten_q;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            chn_q <= 3'h0;
            src_q <= `MCAS_SRC_INT;
            div_q <= `MCAS_DIV_RESET;
            ten_q <= 1'b0;
            converter_faster_q <= 1'b0;
            divisor_rejected <= 1'b0;
            source_rejected <= 1'b0;
            channel_count_rejected <= 1'b0;
        end else if (clk_en && config_write) begin
            ten_q <= ten_bit_variant;
            converter_faster_q <= converter_faster_than_bus;
            divisor_rejected <= !div_ok(clock_divisor);
            if (div_ok(clock_divisor)) div_q <= clock_divisor;
            source_rejected <= (clock_source_select > `MCAS_SRC_SQR);
            if (clock_source_select <= `MCAS_SRC_SQR) src_q <= clock_source_select;
            channel_count_rejected <= (ch_mask(enabled_channel_count) == 4'h0)
                && (enabled_channel_count != 3'h0);
            if (ch_mask(enabled_channel_count) != 4'h0 || enabled_channel_count == 3'h0)
                chn_q <= enabled_channel_count;
        end
    end

    // Source select and divided sampling strobe
    logic src_lvl;
    logic src_prev_q;
    logic src_rise;
    logic [10:0] dcnt_q;
    logic strobe;
    always_comb begin
        case (src_q)
            `MCAS_SRC_SINE: src_lvl = s2_q[1];
            `MCAS_SRC_SQR: src_lvl = s2_q[2];
            default: src_lvl = s2_q[0];
        endcase
    end
    assign src_rise = src_lvl && !src_prev_q;
    assign strobe = src_rise && (dcnt_q == 11'h001);
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            src_prev_q <= 1'b0;
            dcnt_q <= `MCAS_DIV_RESET;
        end else if (clk_en) begin
            src_prev_q <= src_lvl;
            if (src_rise) dcnt_q <= (dcnt_q == 11'h001) ? div_q : dcnt_q - 11'h001;
        end
    end

    // Trigger edge
    logic trig_prev_q;
    logic trig_rise;
    assign trig_rise = s2_q[3] && !trig_prev_q;
    always_ff @(posedge sys_clk) begin
        if (!resetn) trig_prev_q <= 1'b0;
        else if (clk_en) trig_prev_q <= s2_q[3];
    end

    // Acquisition state
    mcas_state_t st_q;
    logic [31:0] left_q;
    logic [1:0] ch_q;
    logic trig_seen_q;
    logic [1:0] last_ch;
    logic emit;
    logic fifo_ready;
    logic done_now;
    assign last_ch = (chn_q == 3'h4) ? `MCAS_CH_LAST4
                   : (chn_q == 3'h2) ? `MCAS_CH_LAST2 : 2'h0;
    assign emit = (st_q == MCAS_RUN || st_q == MCAS_DELAY) && strobe && fifo_ready;
    assign done_now = emit && st_q == MCAS_RUN && left_q == 32'h1;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q <= MCAS_IDLE;
            left_q <= 32'h0;
            trig_seen_q <= 1'b0;
        end else if (clk_en) begin
            case (st_q)
                MCAS_IDLE: begin
                    if (start && chn_q != 3'h0 && conversion_count != 32'h0) begin
                        left_q <= conversion_count;
                        trig_seen_q <= 1'b0;
                        st_q <= use_trigger ? MCAS_WAIT_TRIG : MCAS_RUN;
                    end
                end
                MCAS_WAIT_TRIG: begin
                    if (stop) st_q <= MCAS_IDLE;
                    else if (trig_rise) begin
                        trig_seen_q <= 1'b1;
                        st_q <= (post_trigger_preload != 16'h0) ? MCAS_DELAY : MCAS_RUN;
                    end
                end
                MCAS_DELAY: begin
                    if (stop) st_q <= MCAS_IDLE;
                    else if (post_trigger_remaining == 16'h1 && strobe) st_q <= MCAS_RUN;
                end
                MCAS_RUN: begin
                    if (stop || done_now) st_q <= MCAS_IDLE;
                    else if (emit) left_q <= left_q - 32'h1;
                end
                default: st_q <= MCAS_IDLE;
            endcase
        end
    end

    // Post-trigger counter counts sampling clock edges to zero
    always_ff @(posedge sys_clk) begin
        if (!resetn) post_trigger_remaining <= 16'h0;
        else if (clk_en) begin
            if (st_q == MCAS_WAIT_TRIG && trig_rise) post_trigger_remaining <= post_trigger_preload;
            else if (trig_seen_q && strobe && post_trigger_remaining != 16'h0)
                post_trigger_remaining <= post_trigger_remaining - 16'h1;
        end
    end

    // Channel scan; only RUN emits words
    always_ff @(posedge sys_clk) begin
        if (!resetn) ch_q <= 2'h0;
        else if (clk_en) begin
            if (st_q == MCAS_IDLE) ch_q <= 2'h0;
            else if (emit && st_q == MCAS_RUN)
                ch_q <= (ch_q == last_ch) ? 2'h0 : ch_q + 2'h1;
        end
    end

    // Word packing
    mcas_word_t word;
    logic [11:0] val;
    always_comb begin
        val = ad2_q[ch_q];
        if (ten_q) val[1:0] = 2'h0;
        word = {val, 4'h0};
        word[`MCAS_FLAG_BIT] = trig_seen_q;
        word[2:0] = di2_q;
    end

    mcas_skid mcas_skid_i (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .in_valid(emit && st_q == MCAS_RUN),
        .in_ready(fifo_ready),
        .in_data(word),
        .out_valid(sample_valid),
        .out_ready(sample_ready),
        .out_data(sample_word)
    );

    // Transfer count and ring index
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            transferred_count <= 32'h0;
            oldest_sample_index <= 15'h0;
        end else if (clk_en) begin
            if (st_q == MCAS_IDLE && start && chn_q != 3'h0) begin
                transferred_count <= 32'h0;
                oldest_sample_index <= 15'h0;
            end else if (sample_valid && sample_ready) begin
                transferred_count <= transferred_count + 32'h1;
                if (transferred_count >= {16'h0, `MCAS_BUF_TOTAL} - 32'h1)
                    oldest_sample_index <= oldest_sample_index + 15'h1;
            end
        end
    end

    always_comb begin
        case (st_q)
            MCAS_WAIT_TRIG: acquisition_status = `MCAS_ST_TRIG;
            MCAS_DELAY: acquisition_status = `MCAS_ST_DELAY;
            MCAS_RUN: acquisition_status = `MCAS_ST_XFER;
            default: acquisition_status = `MCAS_ST_DONE;
        endcase
        case (chn_q)
            3'h1: samples_per_channel = `MCAS_BUF_TOTAL;
            3'h2: samples_per_channel = `MCAS_BUF_TOTAL >> 1;
            3'h4: samples_per_channel = `MCAS_BUF_TOTAL >> 2;
            default: samples_per_channel = 16'h0;
        endcase
    end

    property p_zero_stays_done;
        @(posedge sys_clk) disable iff (!resetn)
        (st_q == MCAS_IDLE && chn_q == 3'h0) |=> st_q == MCAS_IDLE;
    endproperty
    a_zero_stays_done: assert property (p_zero_stays_done)
        else $error("acquisition started with no channel");

    property p_four_scan;
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && emit && st_q == MCAS_RUN && chn_q == 3'h4 && ch_q == 2'h3 && !stop)
            |=> ch_q == 2'h0;
    endproperty
    a_four_scan: assert property (p_four_scan)
        else $error("four channel scan did not wrap");

    property p_two_scan;
        @(posedge sys_clk) disable iff (!resetn)
        (chn_q == 3'h2 && st_q == MCAS_RUN) |-> ch_q <= 2'h1;
    endproperty
    a_two_scan: assert property (p_two_scan)
        else $error("two channel scan left channels 0 and 1");

    property p_odd_rejected;
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && config_write && clock_divisor[0]) |=> divisor_rejected && div_q == $past(div_q);
    endproperty
    a_odd_rejected: assert property (p_odd_rejected)
        else $error("odd divisor accepted");

    // A start that is taken: idle, channels enabled and a nonzero count
    sequence s_start_taken;
        clk_en && st_q == MCAS_IDLE && start && chn_q != 3'h0 && conversion_count != 32'h0;
    endsequence

    property p_status_map;
        @(posedge sys_clk) disable iff (!resetn)
        s_start_taken |=>
            acquisition_status == ($past(use_trigger) ? `MCAS_ST_TRIG : `MCAS_ST_XFER);
    endproperty
    a_status_map: assert property (p_status_map)
        else $error("status code wrong after start");

    property p_post_counts;
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && st_q == MCAS_DELAY && strobe) |=>
            post_trigger_remaining == $past(post_trigger_remaining) - 16'h1;
    endproperty
    a_post_counts: assert property (p_post_counts)
        else $error("post trigger counter missed a sampling edge");

    property p_stop_ends;
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && stop && st_q != MCAS_IDLE) |=> acquisition_status == `MCAS_ST_DONE;
    endproperty
    a_stop_ends: assert property (p_stop_ends)
        else $error("stop did not end acquisition");

    property p_count_grows;
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && sample_valid && sample_ready && !start) |=>
            transferred_count == $past(transferred_count) + 32'h1;
    endproperty
    a_count_grows: assert property (p_count_grows)
        else $error("transferred count missed a word");

    property p_post_stops;
        @(posedge sys_clk) disable iff (!resetn)
        (post_trigger_remaining == 16'h0 && !(st_q == MCAS_WAIT_TRIG)) |=>
            post_trigger_remaining == 16'h0;
    endproperty
    a_post_stops: assert property (p_post_stops)
        else $error("post trigger counter moved past zero");
endmodule // mcas_seq
`default_nettype wire

// ---- test/mcas_dma_sink.sv ----
// Host DMA sink model: takes sample words into a host buffer, stalling at random
`default_nettype none
module mcas_dma_sink #(
    parameter int BUF_WORDS = 1024
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic stall_en,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire mcas_pkg::mcas_word_t sample_word
);
    timeunit 1ns;
    timeprecision 1ns;
    import mcas_pkg::*;
    mcas_word_t host_buf [BUF_WORDS];
    int wr_idx;
    // Buffer is larger than any count the bench requests
    always @(posedge sys_clk) begin
        if (!resetn) begin
            wr_idx <= 0;
        end else if (sample_valid && sample_ready) begin
            host_buf[wr_idx] <= sample_word;
            wr_idx <= (wr_idx + 1) % BUF_WORDS;
        end
    end
    always @(posedge sys_clk) begin
        #5;
        sample_ready <= resetn && (!stall_en || ($urandom % 3 != 0));
    end
endmodule // mcas_dma_sink
`default_nettype wire

// ---- test/test_multichannel_adc_acquisition_sequencer.sv ----
// Self-checking bench for the acquisition sequencer with a host DMA sink
`default_nettype none
module test_multichannel_adc_acquisition_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    import mcas_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] ch_count = 3'h0;
    logic [1:0] src_sel = 2'h0;
    logic faster = 1'b0;
    logic [10:0] divisor = 11'h002;
    logic cfg_wr = 1'b0;
    logic ten_bit = 1'b0;
    logic use_trig = 1'b0;
    logic [15:0] preload = 16'h0000;
    logic [31:0] conv_count = 32'h0;
    logic start = 1'b0;
    logic stop = 1'b0;
    logic src_clk = 1'b0;
    logic trig = 1'b0;
    logic [2:0] din = 3'h0;
    logic [11:0] conv_data [4] = '{12'h000, 12'h000, 12'h000, 12'h000};
    logic stall_en = 1'b0;
    logic sample_valid, sample_ready;
    mcas_word_t sample_word;
    logic [1:0] acq_status;
    logic [31:0] xfer_count;
    logic [14:0] oldest_idx;
    logic [15:0] per_chan, post_rem;
    logic div_rej, src_rej, ch_rej, faster_q;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    int seen_words = 0;
    int base = 0;
    int chs [4] = '{0, 1, 2, 4};
    int spc [4] = '{0, 32768, 16384, 8192};
    mcas_word_t exp_q [$];

    mcas_seq mcas_seq_i (
        .sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1),
        .enabled_channel_count(ch_count), .clock_source_select(src_sel),
        .converter_faster_than_bus(faster), .clock_divisor(divisor), .config_write(cfg_wr),
        .ten_bit_variant(ten_bit), .use_trigger(use_trig), .post_trigger_preload(preload),
        .conversion_count(conv_count), .start(start), .stop(stop),
        .internal_clock_tick(src_clk), .external_sine_clock(src_clk),
        .external_square_clock_choice(src_clk), .trigger_in(trig), .digital_inputs(din),
        .converter_data(conv_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_word(sample_word), .acquisition_status(acq_status),
        .transferred_count(xfer_count), .oldest_sample_index(oldest_idx),
        .samples_per_channel(per_chan), .post_trigger_remaining(post_rem),
        .divisor_rejected(div_rej), .source_rejected(src_rej),
        .channel_count_rejected(ch_rej), .converter_faster_q(faster_q)
    );
    mcas_dma_sink mcas_dma_sink_i (
        .sys_clk(sys_clk), .resetn(resetn), .stall_en(stall_en),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_word(sample_word)
    );

    always #50 sys_clk = ~sys_clk;
    // Converter source clock, shared by all three source inputs
    always begin
        repeat (2) @(posedge sys_clk);
        #5;
        src_clk = ~src_clk;
    end

    task automatic conclude();
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            $display("[ERR] %0t timeout", $time);
            conclude();
        end
    end

    task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Scoreboard: every accepted word is matched to the oldest expected one
    always @(posedge sys_clk) begin
        if (resetn && sample_valid === 1'b1 && sample_ready === 1'b1) begin
            seen_words++;
            if (exp_q.size() == 0) begin
                check_eq(32'(sample_word), 32'hffff_ffff, "unexpected word");
            end else begin
                check_eq(32'(sample_word), 32'(exp_q.pop_front()), "sample word");
            end
        end
    end

    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask

    task automatic configure(input logic [2:0] ch, input logic [1:0] src,
                             input logic [10:0] dv, input logic fb, input logic [2:0] rej);
        ch_count = ch;
        src_sel = src;
        divisor = dv;
        faster = fb;
        cfg_wr = 1'b1;
        tick();
        cfg_wr = 1'b0;
        tick();
        check_eq(32'(div_rej), 32'(rej[2]), "divisor reject");
        check_eq(32'(src_rej), 32'(rej[1]), "source reject");
        check_eq(32'(ch_rej), 32'(rej[0]), "channel reject");
        check_eq(32'(faster_q), 32'(fb), "speed setting");
    endtask

    task automatic wait_status(input logic [1:0] st, input int limit);
        int n = 0;
        while (acq_status !== st && n < limit) begin
            tick();
            n++;
        end
        check_eq(32'(acq_status), 32'(st), "status");
    endtask

    task automatic run(input int ch, input int cnt, input logic flag);
        int c;
        foreach (conv_data[k]) conv_data[k] = 12'($urandom);
        din = 3'($urandom);
        for (int i = 0; i < cnt; i++) begin
            c = (ch == 4) ? i % 4 : (ch == 2) ? i % 2 : 0;
            exp_q.push_back({conv_data[c] & (ten_bit ? 12'hffc : 12'hfff), flag, din});
        end
        tick(4);
        conv_count = 32'(cnt);
        start = 1'b1;
        tick();
        start = 1'b0;
        check_eq(32'(acq_status), use_trig ? 32'h2 : 32'h1, "status after start");
    endtask

    task automatic finish_run(input int cnt);
        wait_status(2'h0, 400 * cnt + 400);
        tick(20);
        check_eq(xfer_count, 32'(cnt), "transferred count");
        check_eq(32'(exp_q.size()), 32'h0, "words missing");
    endtask

    initial begin
        void'($urandom(32'h5bfe69cc));
        tick(4);
        resetn = 1'b1;
        tick();
        check_eq(32'(acq_status), 32'h0, "reset status");
        check_eq(xfer_count, 32'h0, "reset count");
        configure(3'h4, 2'h0, 11'h003, 1'b1, 3'h4);
        configure(3'h3, 2'h3, 11'h402, 1'b0, 3'h7);
        check_eq(32'(per_chan), 32'h2000, "count kept");
        configure(3'h4, 2'h0, 11'h000, 1'b0, 3'h4);
        configure(3'h4, 2'h0, 11'h400, 1'b1, 3'h0);
        foreach (chs[k]) begin
            configure(3'(chs[k]), 2'h0, 11'h002, 1'b0, 3'h0);
            check_eq(32'(per_chan), 32'(spc[k]), "buffer split");
        end
        configure(3'h0, 2'h0, 11'h002, 1'b0, 3'h0);
        conv_count = 32'h5;
        start = 1'b1;
        tick();
        start = 1'b0;
        tick(40);
        check_eq(32'(acq_status), 32'h0, "idle with no channel");
        stall_en = 1'b1;
        configure(3'h4, 2'h0, 11'h002, 1'b1, 3'h0);
        run(4, 10, 1'b0);
        finish_run(10);
        ten_bit = 1'b1;
        configure(3'h2, 2'h1, 11'h004, 1'b0, 3'h0);
        run(2, 7, 1'b0);
        finish_run(7);
        ten_bit = 1'b0;
        configure(3'h1, 2'h2, 11'h002, 1'b0, 3'h0);
        run(1, 3, 1'b0);
        finish_run(3);
        configure(3'h4, 2'h0, 11'h002, 1'b0, 3'h0);
        use_trig = 1'b1;
        preload = 16'h0003;
        run(4, 8, 1'b1);
        tick(30);
        check_eq(32'(acq_status), 32'h2, "trigger wait");
        trig = 1'b1;
        wait_status(2'h3, 20);
        wait_status(2'h1, 200);
        finish_run(8);
        check_eq(32'(post_rem), 32'h0, "post trigger count");
        check_eq(32'(oldest_idx), 32'h0, "oldest index");
        trig = 1'b0;
        use_trig = 1'b0;
        configure(3'h1, 2'h0, 11'h002, 1'b0, 3'h0);
        base = seen_words;
        run(1, 500, 1'b0);
        tick(80);
        stop = 1'b1;
        tick();
        stop = 1'b0;
        wait_status(2'h0, 20);
        tick(20);
        check_eq(xfer_count, 32'(seen_words - base), "count at stop");
        check_eq(32'(xfer_count < 32'd500), 32'h1, "stopped early");
        exp_q.delete();
        conclude();
    end
endmodule // test_multichannel_adc_acquisition_sequencer
`default_nettype wire
